// file: logic/flq_pkg.sv
// Constants and types shared by the queue/stack buffer files
package flq_pkg;

  // Store geometry
  localparam int unsigned DEPTH       = 256;
  localparam int unsigned CNT_W       = 9;
  localparam int unsigned PTR_W       = 8;
  localparam int unsigned STAGE_DEPTH = 32;

  localparam logic [CNT_W-1:0] CNT_FULL = 9'h100;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;
  localparam logic [PTR_W-1:0] PTR_ONE  = 8'h01;

  // Bus geometry
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CMD  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_DIN  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_DOUT = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_STAT = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CNT  = 8'h14;

  // Field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CMD_ADV_BIT   = 0;
  localparam int unsigned CMD_CLR_BIT   = 1;
  localparam int unsigned STAT_EMPTY    = 0;
  localparam int unsigned STAT_FULL     = 1;
  localparam int unsigned STAT_PEND     = 2;
  localparam int unsigned STAT_MODE     = 3;

  // Reset values
  localparam logic             CTRL_EN_RST = 1'b0;
  localparam logic [DAT_W-1:0] DAT_ZERO    = 32'h0000_0000;

  typedef enum logic {
    FLQ_MODE_QUEUE = 1'b0,
    FLQ_MODE_STACK = 1'b1
  } flq_mode_t;

endpackage : flq_pkg

// file: logic/flq_stage_fifo.sv
// Staging FIFO between the register bus and the buffer store
`timescale 1ns/1ps
module flq_stage_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);
  localparam logic [LW-1:0] LVL_ZERO = '0;
  localparam logic [PW-1:0] P_ONE    = PW'(1);
  localparam logic [LW-1:0] L_ONE    = LW'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [LW-1:0]               level;
  } flq_stage_t;

  flq_stage_t s_q;
  flq_stage_t s_d;
  logic       push;
  logic       pop;

  assign in_ready  = (s_q.level != LVL_FULL);
  assign out_valid = (s_q.level != LVL_ZERO);
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr          = s_q.wptr + P_ONE;
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + P_ONE;
    end
    if (push && !pop) begin
      s_d.level = s_q.level + L_ONE;
    end else if (pop && !push) begin
      s_d.level = s_q.level - L_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : flq_stage_fifo

// file: logic/flq_top.sv
// Queue/stack word buffer of 256 entries behind a Wishbone slave
`timescale 1ns/1ps
// What this block does
// R1: Word width is 16 or 32 bits per instance, stored and shown signed.
// R2: A write request with enable stores the presented input word as new entry.
// R3: In queue mode the oldest entry stays on the output until advanced.
// R4: Advance with enable on a non-empty buffer discards output entry, shows next.
// R5: In queue mode the second-oldest entry becomes oldest after a discard.
// R6: Holds at most 256 entries; full flag is set at exactly 256.
// R7: Writes while full are ignored; contents and count stay unchanged; code holds the word in staging, stores it once room frees.
// R8: Empty flag is set at zero entries; output value then means nothing.
// R9: Count output equals stored entries, updated on every write and discard.
// R10: Enable with clear empties buffer, zeroes all entries, count zero, empty set.
// R11: In stack mode the newest entry stays on the output until advanced.
// R12: In stack mode the entry written before the newest becomes newest.
// R13: Outputs are registered and hold between updates; one clock only.
// R14: Write and advance in one clock both happen; count stays unchanged.
module flq_top
  import flq_pkg::*;
#(
  parameter int unsigned WORD_W = 32
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADR_W-1:0]  wb_adr,
  input  wire logic [SEL_W-1:0]  wb_sel,
  input  wire logic [DAT_W-1:0]  wb_dat_w,
  output logic      [DAT_W-1:0]  wb_dat_r,
  output logic                   wb_ack,
  output logic      [WORD_W-1:0] q_out,
  output logic      [CNT_W-1:0]  q_count,
  output logic                   q_full,
  output logic                   q_empty
);

  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] mem;
    logic [PTR_W-1:0]             head;
    logic [CNT_W-1:0]             count;
    logic [WORD_W-1:0]            out;
    logic                         full;
    logic                         empty;
    logic                         en;
    flq_mode_t                    mode;
    logic                         adv_req;
    logic                         clr_req;
    logic                         ack;
    logic [DAT_W-1:0]             rdata;
  } flq_state_t;

  flq_state_t        s_q;
  flq_state_t        s_d;

  logic              acc;
  logic              din_hit;
  logic [DAT_W-1:0]  wmask;
  logic [DAT_W-1:0]  wval;
  logic              stg_push;
  logic              stg_ready;
  logic              stg_valid;
  logic [WORD_W-1:0] stg_data;
  logic              wr_ok;
  logic              adv_ok;
  logic              clr_ok;
  logic [PTR_W-1:0]  tail;
  logic [PTR_W-1:0]  wr_idx;
  logic [PTR_W-1:0]  out_idx;
  logic [DAT_W-1:0]  rd_mux;
  logic [DAT_W-1:0]  out_ext;

  // Byte-lane merge of write data
  genvar gb;
  generate
    for (gb = 0; gb < SEL_W; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{wb_sel[gb]}};
    end
  endgenerate

  assign wval    = wb_dat_w & wmask;
  assign acc     = wb_cyc && wb_stb;
  assign din_hit = (wb_adr == OFS_DIN);
  assign out_ext = DAT_W'(signed'(s_q.out)); // see R1

  // Pushes land at the write edge of a data-in access
  assign stg_push = acc && s_q.ack && wb_we && din_hit; // see R2

  flq_stage_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (stg_push),
    .in_ready  (stg_ready),
    .in_data   (wval[WORD_W-1:0]),
    .out_valid (stg_valid),
    .out_ready (wr_ok),
    .out_data  (stg_data)
  );

  // Accepted operations
  assign clr_ok = s_q.en && s_q.clr_req; // see R10
  assign wr_ok  = s_q.en && stg_valid && !s_q.full && !clr_ok; // see R2, R7
  assign adv_ok = s_q.en && s_q.adv_req && !s_q.empty && !clr_ok; // see R4
  assign tail   = s_q.head + s_q.count[PTR_W-1:0];

  // Read mux
  always_comb begin
    rd_mux = DAT_ZERO;
    unique case (wb_adr)
      OFS_CTRL: begin
        rd_mux[CTRL_EN_BIT]   = s_q.en;
        rd_mux[CTRL_MODE_BIT] = s_q.mode;
      end
      OFS_DOUT: begin
        rd_mux = out_ext;
      end
      OFS_STAT: begin
        rd_mux[STAT_EMPTY] = s_q.empty;
        rd_mux[STAT_FULL]  = s_q.full;
        rd_mux[STAT_PEND]  = stg_valid;
        rd_mux[STAT_MODE]  = s_q.mode;
      end
      OFS_CNT: begin
        rd_mux = DAT_W'(s_q.count);
      end
      default: begin
        rd_mux = DAT_ZERO;
      end
    endcase
  end

  always_comb begin
    s_d         = s_q;
    s_d.ack     = 1'b0;
    s_d.adv_req = 1'b0;
    s_d.clr_req = 1'b0;
    wr_idx      = tail;
    out_idx     = s_q.head;

    // Bus answer; data-in writes wait for room in the staging FIFO
    if (acc && !s_q.ack && (!(wb_we && din_hit) || stg_ready)) begin
      s_d.ack   = 1'b1;
      s_d.rdata = wb_we ? DAT_ZERO : rd_mux;
    end

    // Register writes take effect at the acknowledged edge
    if (acc && s_q.ack && wb_we && wb_sel[0]) begin
      if (wb_adr == OFS_CTRL) begin
        s_d.en   = wval[CTRL_EN_BIT];
        s_d.mode = flq_mode_t'(wval[CTRL_MODE_BIT]);
      end
      if (wb_adr == OFS_CMD) begin
        s_d.adv_req = wval[CMD_ADV_BIT];
        s_d.clr_req = wval[CMD_CLR_BIT];
      end
    end

    // Store update
    if (clr_ok) begin
      s_d.mem   = '0; // see R10
      s_d.head  = '0;
      s_d.count = CNT_ZERO;
    end else begin
      if (wr_ok) begin
        // Stack with advance replaces the top in place
        if (s_q.mode == FLQ_MODE_STACK && adv_ok) begin
          wr_idx = tail - PTR_ONE; // see R14
        end
        s_d.mem[wr_idx] = stg_data; // see R2
      end
      if (adv_ok && s_q.mode == FLQ_MODE_QUEUE) begin
        s_d.head = s_q.head + PTR_ONE; // see R5
      end
      if (wr_ok && !adv_ok) begin
        s_d.count = s_q.count + CNT_ONE; // see R9
      end else if (adv_ok && !wr_ok) begin
        s_d.count = s_q.count - CNT_ONE; // see R4, R9
      end
    end

    s_d.full  = (s_d.count == CNT_FULL); // see R6
    s_d.empty = (s_d.count == CNT_ZERO); // see R8

    // Output entry: oldest for queue, newest for stack
    if (s_d.mode == FLQ_MODE_STACK) begin
      out_idx = s_d.head + s_d.count[PTR_W-1:0] - PTR_ONE; // see R11, R12
    end else begin
      out_idx = s_d.head; // see R3
    end
    s_d.out = s_d.mem[out_idx]; // see R13
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q       <= '0;
      s_q.en    <= CTRL_EN_RST;
      s_q.mode  <= FLQ_MODE_QUEUE;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_r = s_q.rdata;
  assign wb_ack   = s_q.ack;
  assign q_out    = s_q.out;
  assign q_count  = s_q.count;
  assign q_full   = s_q.full;
  assign q_empty  = s_q.empty;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic [WORD_W-1:0] nxt_old;
  logic [WORD_W-1:0] nxt_new;
  logic              idle;

  assign nxt_old = s_q.mem[s_q.head + PTR_ONE];
  assign nxt_new = s_q.mem[tail - PTR_ONE - PTR_ONE];
  assign idle    = !wr_ok && !adv_ok && !clr_ok;

  AST_WIDTH: assert property ((WORD_W == 16) || (WORD_W == 32)) // see R1
    else $error("word width is neither 16 nor 32");

  AST_WRITE_GROWS: assert property ( // see R2
    wr_ok && !adv_ok |=> q_count == $past(q_count) + CNT_ONE && !q_empty)
    else $error("accepted write did not add one entry");

  AST_QUEUE_HOLD: assert property ( // see R3
    s_q.mode == FLQ_MODE_QUEUE && !q_empty && !adv_ok && !clr_ok
    ##1 s_q.mode == FLQ_MODE_QUEUE |-> $stable(q_out))
    else $error("queue output changed without a discard");

  AST_ADVANCE_SHRINKS: assert property ( // see R4
    adv_ok && !wr_ok |=> q_count == $past(q_count) - CNT_ONE)
    else $error("advance did not remove one entry");

  AST_QUEUE_NEXT: assert property ( // see R5
    s_q.mode == FLQ_MODE_QUEUE && adv_ok && !wr_ok && q_count > CNT_ONE
    ##1 s_q.mode == FLQ_MODE_QUEUE |-> q_out == $past(nxt_old))
    else $error("queue did not present second-oldest entry");

  AST_FULL_FLAG: assert property ( // see R6
    q_count <= CNT_FULL && (q_full == (q_count == CNT_FULL)))
    else $error("full flag does not match 256 entries");

  AST_FULL_IGNORES: assert property ( // see R7
    q_full && stg_valid && s_q.en && !adv_ok && !clr_ok |=> q_full && $stable(q_count))
    else $error("write while full changed the store");

  AST_EMPTY_FLAG: assert property ( // see R8
    q_empty == (q_count == CNT_ZERO))
    else $error("empty flag does not match zero entries");

  AST_IDLE_COUNT: assert property ( // see R9
    idle |=> $stable(q_count) [*1] ##0 $stable(s_q.head))
    else $error("count moved without write or discard");

  AST_CLEAR: assert property ( // see R10
    clr_ok |=> q_empty && q_count == CNT_ZERO && s_q.mem == '0)
    else $error("clear did not empty and zero the store");

  AST_STACK_PUSH: assert property ( // see R11
    s_q.mode == FLQ_MODE_STACK && wr_ok ##1 s_q.mode == FLQ_MODE_STACK
    |-> q_out == $past(stg_data))
    else $error("stack output is not the newest write");

  AST_STACK_POP: assert property ( // see R12
    s_q.mode == FLQ_MODE_STACK && adv_ok && !wr_ok && q_count > CNT_ONE
    ##1 s_q.mode == FLQ_MODE_STACK |-> q_out == $past(nxt_new))
    else $error("stack did not present the prior entry");

  AST_OUT_STEADY: assert property ( // see R13
    idle ##1 $stable(s_q.mode) |-> $stable(q_out))
    else $error("output moved between updates");

  AST_BOTH_OPS: assert property ( // see R14
    wr_ok && adv_ok |=> $stable(q_count) && !q_empty)
    else $error("write plus advance changed the count");

  AST_PUSH_STAGED: assert property ( // see R2
    stg_push |=> stg_valid)
    else $error("data-in write did not reach staging");

  AST_OFF_FROZEN: assert property ( // see R2
    !s_q.en |=> $stable(q_count) && $stable(s_q.head))
    else $error("store changed while disabled");

  AST_EMPTY_STAYS: assert property ( // see R8
    q_empty && !wr_ok |=> q_empty)
    else $error("empty store left empty without a write");

  AST_QUEUE_FIRST: assert property ( // see R3
    s_q.mode == FLQ_MODE_QUEUE && q_empty && wr_ok ##1 s_q.mode == FLQ_MODE_QUEUE
    |-> q_out == $past(stg_data))
    else $error("first queue entry not shown");

  AST_FULL_STAYS: assert property ( // see R7
    q_full && !adv_ok && !clr_ok |=> q_full)
    else $error("full store left full without a discard");

  AST_FULL_ON_LAST: assert property ( // see R6
    wr_ok && !adv_ok && q_count == CNT_FULL - CNT_ONE |=> q_full)
    else $error("last free entry written but not full");

  AST_FULL_NEVER_EMPTY: assert property ( // see R6
    !(q_full && q_empty))
    else $error("full and empty at once");

  AST_CLEAR_OUT_ZERO: assert property ( // see R10
    clr_ok |=> q_out == '0)
    else $error("output not zero after clear");

  AST_OFF_NO_CLEAR: assert property ( // see R10
    !s_q.en && s_q.clr_req |=> $stable(s_q.mem))
    else $error("clear acted while disabled");

  AST_STACK_HEAD_FIXED: assert property ( // see R12
    s_q.mode == FLQ_MODE_STACK && !clr_ok |=> $stable(s_q.head))
    else $error("stack base moved");

  AST_CMD_PULSE: assert property ( // see R4
    s_q.adv_req |=> !s_q.adv_req)
    else $error("advance request held longer than one cycle");

  AST_ACK_AFTER_REQ: assert property (
    wb_cyc && wb_stb && !wb_ack && !(wb_we && wb_adr == OFS_DIN) |=> wb_ack)
    else $error("register access not answered in one cycle");

  AST_RDATA_HOLD: assert property (
    !(wb_cyc && wb_stb) |=> $stable(wb_dat_r))
    else $error("read data moved without a request");

  AST_CTRL_WRITE: assert property (
    wb_cyc && wb_stb && wb_ack && wb_we && wb_adr == OFS_CTRL && wb_sel[0]
    |=> s_q.en == $past(wb_dat_w[CTRL_EN_BIT]))
    else $error("enable write did not land at acknowledge");

  AST_ACK_ONE: assert property (
    wb_ack |=> !wb_ack)
    else $error("acknowledge held longer than one cycle");

endmodule : flq_top

// file: tb/flq_app_model.sv
// Application-side bus master model for the buffer registers
`timescale 1ns/1ps
module flq_app_model
  import flq_pkg::*;
(
  input  wire logic             ref_clk,
  output logic                  wb_cyc,
  output logic                  wb_stb,
  output logic                  wb_we,
  output logic      [ADR_W-1:0] wb_adr,
  output logic      [SEL_W-1:0] wb_sel,
  output logic      [DAT_W-1:0] wb_dat_w,
  input  wire logic [DAT_W-1:0] wb_dat_r,
  input  wire logic             wb_ack
);
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
  end

  // One classic cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [ADR_W-1:0] adr,
                     input logic [DAT_W-1:0] dat, output logic [DAT_W-1:0] rdat);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat_w <= dat;
    @(posedge ref_clk);
    while (wb_ack !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdat = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_dat_w <= ~dat;
  endtask : bus
endmodule : flq_app_model

// file: tb/tb.sv
// Self-checking bench for the queue/stack buffer
`timescale 1ns/1ps
module tb;
  import flq_pkg::*;
  localparam int unsigned W = 16;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              wb_cyc;
  logic              wb_stb;
  logic              wb_we;
  logic [ADR_W-1:0]  wb_adr;
  logic [SEL_W-1:0]  wb_sel;
  logic [DAT_W-1:0]  wb_dat_w;
  logic [DAT_W-1:0]  wb_dat_r;
  logic              wb_ack;
  logic [W-1:0]      q_out;
  logic [CNT_W-1:0]  q_count;
  logic              q_full;
  logic              q_empty;
  int                fails = 0;
  int                num_checks = 0;

  flq_top #(.WORD_W(W)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .q_out(q_out),
    .q_count(q_count), .q_full(q_full), .q_empty(q_empty));

  flq_app_model i_app (.ref_clk(ref_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // State of the buffer ports
  task automatic chk_q(input logic [31:0] cnt, input logic [31:0] outv);
    chk("q_count", cnt, 32'(q_count));
    chk("q_empty", 32'(cnt == 0), 32'(q_empty));
    chk("q_full", 32'(cnt == 256), 32'(q_full));
    if (cnt != 0) chk("q_out", outv, 32'(q_out));
  endtask : chk_q

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
    logic [31:0] r;
    i_app.bus(1'b1, adr, dat, r);
    repeat (3) @(posedge ref_clk);
  endtask : wr

  task automatic rd(input string name, input logic [ADR_W-1:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    i_app.bus(1'b0, adr, 32'h0, r);
    chk(name, exp, r);
  endtask : rd

  task automatic t_reset;
    chk_q(0, 0);
    wr(8'h40, 32'h1);
    rd("unmapped", 8'h40, 32'h0);
    rd("ctrl", OFS_CTRL, 32'h0);
  endtask : t_reset

  task automatic t_queue;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CMD, 32'h1);
    chk_q(0, 0);
    wr(OFS_DIN, 32'h5);
    wr(OFS_DIN, 32'h64);
    wr(OFS_DIN, 32'hffff_fff0);
    chk_q(3, 32'h5);
    rd("dout", OFS_DOUT, 32'h5);
    wr(OFS_CMD, 32'h1);
    chk_q(2, 32'h64);
    wr(OFS_CMD, 32'h1);
    rd("dout", OFS_DOUT, 32'hffff_fff0);
    wr(OFS_CMD, 32'h2);
    chk_q(0, 0);
  endtask : t_queue

  task automatic t_stack;
    wr(OFS_CTRL, 32'h3);
    rd("ctrl", OFS_CTRL, 32'h3);
    wr(OFS_DIN, 32'h7);
    wr(OFS_DIN, 32'h9);
    chk_q(2, 32'h9);
    repeat (5) @(posedge ref_clk);
    chk_q(2, 32'h9);
    wr(OFS_CMD, 32'h1);
    chk_q(1, 32'h7);
    wr(OFS_CMD, 32'h2);
    chk_q(0, 0);
  endtask : t_stack

  task automatic t_full;
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 256; i++) begin
      wr(OFS_DIN, 32'(i + 1));
    end
    chk_q(256, 32'h1);
    wr(OFS_DIN, 32'h0abc);
    repeat (4) @(posedge ref_clk);
    chk_q(256, 32'h1);
    rd("stat", OFS_STAT, 32'h6);
    rd("cnt", OFS_CNT, 32'h100);
    wr(OFS_CMD, 32'h2);
    repeat (4) @(posedge ref_clk);
    chk_q(1, 32'h0abc);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CMD, 32'h2);
    chk_q(1, 32'h0abc);
  endtask : t_full

  // Write and advance landing in the same clock
  task automatic t_both;
    logic [31:0] r;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_DIN, 32'h11 + 32'(i));
    end
    chk_q(1, 32'h0abc);
    rd("pend", OFS_STAT, 32'h4);
    i_app.bus(1'b1, OFS_CTRL, 32'h1, r);
    i_app.bus(1'b1, OFS_CMD, 32'h1, r);
    repeat (2) @(posedge ref_clk);
    chk("q_count", 32'h4, 32'(q_count));
    repeat (2) @(posedge ref_clk);
    chk_q(5, 32'h11);
  endtask : t_both

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_queue();
    t_stack();
    t_full();
    t_both();
    finish_test();
  end
endmodule : tb
